// ### logic/astx_defines.svh
/*
  Register offsets, field positions, reset values and timing figures of the
  audio serial transmitter. Assumes byte addresses on an 8-bit APB address.
*/
`ifndef ASTX_DEFINES_SVH
`define ASTX_DEFINES_SVH
`define ASTX_A_CTRL     8'h00
`define ASTX_A_SLOT     8'h04
`define ASTX_A_HALF     8'h08
`define ASTX_A_STATUS   8'h0C
`define ASTX_A_DATA     4'h1
`define ASTX_CTRL_RST   32'h0000_000C
`define ASTX_SLOT_RST   24'h00_0000
`define ASTX_HALF_RST   11'h020
`define ASTX_FMT_TDM    2'h0
`define ASTX_FMT_I2S    2'h1
`define ASTX_FMT_LJ     2'h2
`define ASTX_WORD_MSB   5'h1F
`define ASTX_LAST_SLOT  5'h1F
`define ASTX_PCLK_HZ    250000000
`define ASTX_BCLK_MAX_KHZ 24576
`define ASTX_RATES      9
`endif

// ### logic/astx_pkg.sv
/*
  Types of the audio serial transmitter: control word, detect result,
  auto clock settings, APB carriers and the shifter states.
  Assumes astx_defines.svh sits on the include path.
*/
package astx_pkg;
  typedef struct packed {
    logic [16:0] rsvd;
    logic        fs_master;
    logic        late_latch;
    logic        lane2_en;
    logic        keeper_en;
    logic        tristate_en;
    logic        bit_clock_invert;
    logic [4:0]  slot_delay;
    logic [1:0]  wlen;
    logic [1:0]  serial_framing_select;
  } astx_ctrl_t;
  typedef struct packed {
    logic [21:0] rsvd;
    logic        clk_err;
    logic        valid;
    logic [3:0]  rate_idx;
    logic [3:0]  ratio_idx;
  } astx_status_t;
  typedef struct packed {
    logic        valid;
    logic [3:0]  rate_idx;
    logic [3:0]  ratio_idx;
    logic [11:0] filt_div;
  } astx_clk_cfg_t;
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } astx_apb_req_t;
  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } astx_apb_rsp_t;
  typedef enum logic [1:0] {ST_IDLE, ST_DELAY, ST_SHIFT} astx_state_t;
endpackage

// ### logic/astx_top.sv
/*
  I2S / left-justified multichannel transmitter with frame-rate and
  bit-clock-ratio detection, behind an APB slave.
  Assumes bit clock and frame sync are synchronous to pclk and at most a
  tenth of its rate; the pad logic resolves the three-signal pins.
*/
// Register access over APB and the placing of the registers were decided locally.
// Notes on behaviour
// - I2S left MSB one cycle after sync fall
// - I2S right MSB one cycle after sync rise
// - Remaining slots follow back to back ascending
// - I2S own sync and data on falling edges
// - LJ left MSB in the same cycle
// - LJ later bits on falling edges
// - LJ right MSB on a falling edge
// - LJ own sync changes on falling edges
// - Channels map onto any of 64 slots
// - Optional tri-state in slots not owned
// - Optional keeper holds last data level
// - Second data lane selectable
// - Optional latch half a cycle after launch
// - Clocks derived by measuring sync and bit clock
// - Accept 8-768 kHz, ratios 16-2048, not reserved
// - Dividers set from detection, no writes
// - Unsupported pair flags error and mutes
// - Two-bit framing select, 11 reserved
// - Five-bit delay postpones slots 0-31 cycles
`timescale 1ns/1ps
`include "astx_defines.svh"
module astx_top #(
  parameter int PCLK_HZ = `ASTX_PCLK_HZ
) (
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  input  wire astx_pkg::astx_apb_req_t apb_req,
  output      astx_pkg::astx_apb_rsp_t apb_rsp,
  input  wire logic                    bclk_pin,
  input  wire logic                    frame_sync_pin,
  output      logic                    frame_sync_o,
  output      logic                    frame_sync_oe,
  output      logic [1:0]              sdout_o,
  output      logic [1:0]              sdout_oe,
  output      logic [1:0]              sdout_hold,
  output      astx_pkg::astx_clk_cfg_t clk_cfg,
  output      logic                    record_mute
);
  import astx_pkg::*;

  function automatic int rate_khz(input int i);
    case (i)
      0: rate_khz = 8;
      1: rate_khz = 16;
      2: rate_khz = 24;
      3: rate_khz = 32;
      4: rate_khz = 48;
      5: rate_khz = 96;
      6: rate_khz = 192;
      7: rate_khz = 384;
      default: rate_khz = 768;
    endcase
  endfunction

  function automatic int ratio_val(input logic [3:0] i);
    case (i)
      4'h0: ratio_val = 16;
      4'h1: ratio_val = 24;
      4'h2: ratio_val = 32;
      4'h3: ratio_val = 48;
      4'h4: ratio_val = 64;
      4'h5: ratio_val = 96;
      4'h6: ratio_val = 128;
      4'h7: ratio_val = 192;
      4'h8: ratio_val = 256;
      4'h9: ratio_val = 384;
      4'hA: ratio_val = 512;
      4'hB: ratio_val = 1024;
      4'hC: ratio_val = 2048;
      default: ratio_val = 0;
    endcase
  endfunction

  function automatic logic [4:0] word_lsb(input logic [1:0] w);
    case (w)
      2'h0: word_lsb = 5'h10;
      2'h1: word_lsb = 5'h0C;
      2'h2: word_lsb = 5'h08;
      default: word_lsb = 5'h00;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // APB registers: zero wait states, read data captured in setup
  astx_ctrl_t   ctrl, next_ctrl;
  logic [23:0]  slot_map, next_slot_map;
  logic [10:0]  half_len, next_half_len;
  logic [31:0]  ch_data [4];
  logic [31:0]  next_ch_data [4];
  logic [31:0]  prdata, next_prdata;
  astx_status_t status;
  logic         wr, dhit, hit;
  logic [31:0]  rd;

  always_comb begin
    wr = apb_req.psel & apb_req.penable & apb_req.pwrite;
    dhit = apb_req.paddr[7:4] == `ASTX_A_DATA;
    next_ctrl = ctrl;
    next_slot_map = slot_map;
    next_half_len = half_len;
    next_ch_data = ch_data;
    hit = 1'b1;
    rd = 32'h0000_0000;
    case (apb_req.paddr)
      `ASTX_A_CTRL: rd = ctrl;
      `ASTX_A_SLOT: rd = {8'h00, slot_map};
      `ASTX_A_HALF: rd = {21'h00_0000, half_len};
      `ASTX_A_STATUS: rd = status;
      default: begin
        hit = dhit & (apb_req.paddr[1:0] == 2'h0);
        rd = hit ? ch_data[apb_req.paddr[3:2]] : 32'h0000_0000;
      end
    endcase
    if (wr && hit) begin
      case (apb_req.paddr)
        `ASTX_A_CTRL: next_ctrl = {17'h0_0000, apb_req.pwdata[14:0]};
        `ASTX_A_SLOT: next_slot_map = apb_req.pwdata[23:0];
        `ASTX_A_HALF: next_half_len = apb_req.pwdata[10:0];
        `ASTX_A_STATUS: next_ctrl = ctrl;
        default: next_ch_data[apb_req.paddr[3:2]] = apb_req.pwdata;
      endcase
    end
    next_prdata = (apb_req.psel & ~apb_req.penable) ? rd : prdata;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= astx_ctrl_t'(`ASTX_CTRL_RST);
      slot_map <= `ASTX_SLOT_RST;
      half_len <= `ASTX_HALF_RST;
      ch_data <= '{default: 32'h0000_0000};
      prdata <= 32'h0000_0000;
    end else begin
      ctrl <= next_ctrl;
      slot_map <= next_slot_map;
      half_len <= next_half_len;
      ch_data <= next_ch_data;
      prdata <= next_prdata;
    end
  end

  assign apb_rsp.pready = 1'b1;
  assign apb_rsp.pslverr = apb_req.psel & apb_req.penable & ~hit;
  assign apb_rsp.prdata = prdata;

  ////////////////////////////////////////////////////////////////////////
  // Edge detection and clock auto-detect
  logic         bclk_e, bclk_prev, fs_prev, fs_reg, fs_now;
  logic         launch, sample, fs_chg;
  logic [16:0]  pcnt, next_pcnt;
  logic [11:0]  bcnt, next_bcnt;
  astx_status_t next_status;
  logic [`ASTX_RATES-1:0] rate_hit;

  assign bclk_e = bclk_pin ^ ctrl.bit_clock_invert;
  assign launch = bclk_prev & ~bclk_e;
  assign sample = ~bclk_prev & bclk_e;
  assign fs_now = ctrl.fs_master ? fs_reg : frame_sync_pin;
  assign fs_chg = fs_now != fs_prev;

  // Window of one sixteenth tolerates host clock error
  for (genvar r = 0; r < `ASTX_RATES; r++) begin : g_rate
    localparam int P = PCLK_HZ / (rate_khz(r) * 1000);
    assign rate_hit[r] = (pcnt >= 17'(P - P / 16)) && (pcnt <= 17'(P + P / 16));
  end

  always_comb begin
    next_status = status;
    next_pcnt = (&pcnt) ? pcnt : pcnt + 17'h0_0001;
    next_bcnt = (sample && !(&bcnt)) ? bcnt + 12'h001 : bcnt;
    if (fs_now && !fs_prev) begin
      next_pcnt = 17'h0_0001;
      next_bcnt = 12'h000;
      next_status.rate_idx = 4'hF;
      next_status.ratio_idx = 4'hF;
      for (int r = 0; r < `ASTX_RATES; r++) begin
        if (rate_hit[r]) next_status.rate_idx = 4'(r);
      end
      for (int k = 0; k < 13; k++) begin
        if (ratio_val(4'(k)) == int'(bcnt)) next_status.ratio_idx = 4'(k);
      end
      next_status.valid = next_status.rate_idx != 4'hF && next_status.ratio_idx != 4'hF;
      // Reserved pairs: bit clock above the top rate, or 8 kHz under 32
      next_status.clk_err = !next_status.valid ||
        ratio_val(next_status.ratio_idx) * rate_khz(int'(next_status.rate_idx))
          > `ASTX_BCLK_MAX_KHZ ||
        (next_status.rate_idx == 4'h0 && next_status.ratio_idx < 4'h2);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bclk_prev <= 1'b0;
      fs_prev <= 1'b0;
      pcnt <= 17'h0_0000;
      bcnt <= 12'h000;
      status <= '0;
    end else begin
      bclk_prev <= bclk_e;
      fs_prev <= fs_now;
      pcnt <= next_pcnt;
      bcnt <= next_bcnt;
      status <= next_status;
    end
  end

  assign clk_cfg.valid = status.valid & ~status.clk_err;
  assign clk_cfg.rate_idx = status.rate_idx;
  assign clk_cfg.ratio_idx = status.ratio_idx;
  assign clk_cfg.filt_div = 12'(`ASTX_BCLK_MAX_KHZ / rate_khz(int'(status.rate_idx)));
  assign record_mute = status.clk_err;

  ////////////////////////////////////////////////////////////////////////
  // Slot shifter, own frame sync and the two data lanes
  astx_state_t state, next_state;
  logic        right, next_right, next_fs_reg, i2s, fmt_ok;
  logic [5:0]  dcnt, next_dcnt, dly;
  logic [4:0]  bit_idx, next_bit_idx, slot, next_slot;
  logic [10:0] fcnt, next_fcnt;
  logic [1:0]  core_own, core_bit, next_sd, next_oe;

  always_comb begin
    i2s = ctrl.serial_framing_select == `ASTX_FMT_I2S;
    fmt_ok = i2s || ctrl.serial_framing_select == `ASTX_FMT_LJ;
    dly = {1'b0, ctrl.slot_delay} + {5'h00, i2s};
    next_state = state;
    next_right = right;
    next_dcnt = dcnt;
    next_bit_idx = bit_idx;
    next_slot = slot;
    next_fs_reg = fs_reg;
    next_fcnt = fcnt;
    if (ctrl.fs_master && launch) begin
      if (fcnt >= half_len - 11'h001) begin
        next_fs_reg = ~fs_reg;
        next_fcnt = 11'h000;
      end else begin
        next_fcnt = fcnt + 11'h001;
      end
    end
    if (!fmt_ok) begin
      next_state = ST_IDLE;
    end else if (fs_chg) begin
      next_right = i2s ? fs_now : ~fs_now;
      next_bit_idx = `ASTX_WORD_MSB;
      next_slot = 5'h00;
      next_dcnt = dly - 6'h01;
      next_state = (dly == 6'h00) ? ST_SHIFT : ST_DELAY;
    end else if (launch) begin
      case (state)
        ST_DELAY: begin
          if (dcnt == 6'h00) next_state = ST_SHIFT;
          else next_dcnt = dcnt - 6'h01;
        end
        ST_SHIFT: begin
          if (bit_idx == word_lsb(ctrl.wlen)) begin
            next_bit_idx = `ASTX_WORD_MSB;
            next_slot = slot + 5'h01;
            if (slot == `ASTX_LAST_SLOT) next_state = ST_IDLE;
          end else begin
            next_bit_idx = bit_idx - 5'h01;
          end
        end
        default: next_state = ST_IDLE;
      endcase
    end
    next_sd = sdout_o;
    next_oe = sdout_oe;
    for (int l = 0; l < 2; l++) begin
      core_own[l] = 1'b0;
      core_bit[l] = 1'b0;
      for (int c = 0; c < 4; c++) begin
        if (next_state == ST_SHIFT && slot_map[6*c +: 6] == {next_right, next_slot} &&
            (ctrl.lane2_en && c >= 2) == (l == 1)) begin
          core_own[l] = 1'b1;
          core_bit[l] = ~status.clk_err & ch_data[c][next_bit_idx];
        end
      end
      // Relaxed latching moves each bit to the sample edge after launch
      if (!ctrl.late_latch || sample) begin
        next_oe[l] = core_own[l] | ~ctrl.tristate_en;
        if (core_own[l]) next_sd[l] = core_bit[l];
        else if (!ctrl.tristate_en) next_sd[l] = 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_IDLE;
      right <= 1'b0;
      dcnt <= 6'h00;
      bit_idx <= `ASTX_WORD_MSB;
      slot <= 5'h00;
      fs_reg <= 1'b0;
      fcnt <= 11'h000;
      sdout_o <= 2'h0;
      sdout_oe <= 2'h0;
    end else begin
      state <= next_state;
      right <= next_right;
      dcnt <= next_dcnt;
      bit_idx <= next_bit_idx;
      slot <= next_slot;
      fs_reg <= next_fs_reg;
      fcnt <= next_fcnt;
      sdout_o <= next_sd;
      sdout_oe <= next_oe;
    end
  end

  assign sdout_hold = {2{ctrl.keeper_en}} & ~sdout_oe;
  assign frame_sync_o = fs_reg;
  assign frame_sync_oe = ctrl.fs_master;

  ////////////////////////////////////////////////////////////////////////
  i2s_msb_a: assert property (@(posedge pclk) disable iff (!presetn)
    fs_chg && i2s && ctrl.slot_delay == 5'h00 |=> state == ST_DELAY && dcnt == 6'h00)
    else $error("I2S MSB not one launch after sync edge");
  lj_msb_a: assert property (@(posedge pclk) disable iff (!presetn)
    fs_chg && fmt_ok && !i2s && ctrl.slot_delay == 5'h00
      |=> state == ST_SHIFT && bit_idx == 5'h1F && slot == 5'h00)
    else $error("LJ MSB not presented at once");
  delay_len_a: assert property (@(posedge pclk) disable iff (!presetn)
    fs_chg && fmt_ok && ctrl.slot_delay != 5'h00 |=> dcnt == $past(dly) - 6'h01)
    else $error("Slot delay count wrong");
  bit_edge_a: assert property (@(posedge pclk) disable iff (!presetn)
    state == ST_SHIFT && !launch && !fs_chg && fmt_ok |=> $stable(bit_idx))
    else $error("Data bit moved off a launch edge");
  slot_order_a: assert property (@(posedge pclk) disable iff (!presetn)
    fmt_ok && state == ST_SHIFT && launch && !fs_chg && bit_idx == word_lsb(ctrl.wlen)
      && slot != 5'h1F |=> slot == $past(slot) + 5'h01 && bit_idx == 5'h1F)
    else $error("Slots not in ascending order");
  own_sync_a: assert property (@(posedge pclk) disable iff (!presetn)
    $changed(fs_reg) |-> $past(launch) && $past(ctrl.fs_master))
    else $error("Own frame sync moved off a falling edge");
  mute_a: assert property (@(posedge pclk) disable iff (!presetn)
    status.clk_err && !ctrl.late_latch ##1 status.clk_err |-> (sdout_o & sdout_oe) == 2'h0)
    else $error("Data not muted on clock error");
  tristate_a: assert property (@(posedge pclk) disable iff (!presetn)
    ctrl.tristate_en && !ctrl.late_latch && core_own == 2'h0 |=> sdout_oe == 2'h0)
    else $error("Lane driven in a foreign slot");
  late_a: assert property (@(posedge pclk) disable iff (!presetn)
    ctrl.late_latch && !sample |=> $stable(sdout_o))
    else $error("Relaxed latching changed data off sample edge");
endmodule

// ### test/astx_host_model.sv
/*
  Host side of the serial bus: makes bit clock and frame sync from pclk and
  shifts both data lanes in on bit-clock rising edges.
  Assumes the bench resolves each lane to a level, or z when nobody drives.
*/
`timescale 1ns/1ps
module astx_host_model (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [10:0] half_n,
  input  wire logic [1:0]  sd,
  output      logic        bclk,
  output      logic        fs,
  output      int          cnt,
  output      logic [31:0] cap0,
  output      logic [31:0] cap1
);
  logic [3:0]  ph;
  logic [10:0] bc;

  ////////////////////////////////////////////////////////////////////////////
  // Ten pclk per bit clock keeps each phase above the two-pclk minimum
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ph   <= 4'h0;
      bc   <= 11'h000;
      // Idle low, as the block's edge detector expects after reset
      bclk <= 1'b0;
      fs   <= 1'b0;
      cnt  <= 0;
      cap0 <= '0;
      cap1 <= '0;
    end else begin
      ph <= (ph == 4'h9) ? 4'h0 : ph + 4'h1;
      if (ph == 4'h4) begin
        bclk <= 1'b0;
        // Sync flips on a launch edge once a whole half has gone by
        // A shortened half mid-frame must not let the counter run to wrap
        if (bc >= half_n - 11'h001) begin
          bc   <= 11'h000;
          fs   <= ~fs;
          cnt  <= 0;
          cap0 <= '0;
          cap1 <= '0;
        end else begin
          bc <= bc + 11'h001;
        end
      end
      if (ph == 4'h9) begin
        bclk <= 1'b1;
        cnt  <= cnt + 1;
        cap0 <= {cap0[30:0], sd[0]};
        cap1 <= {cap1[30:0], sd[1]};
      end
    end
  end
endmodule

// ### test/astx_top_tb.sv
/*
  Self-checking bench of astx_top: APB master tasks, host clock model,
  framing, slot and clock detection scenarios.
  Assumes astx_host_model and the design package are compiled first.
*/
`timescale 1ns/1ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin n_mismatch++; \
  $display("unexpected at %0t: got %h expected %h", $time, g, e); end end
module astx_top_tb;
  import astx_pkg::*;
  logic          pclk;
  logic          presetn;
  astx_apb_req_t req;
  astx_apb_rsp_t rsp;
  astx_clk_cfg_t cfg;
  logic          mute;
  logic [1:0]    so;
  logic [1:0]    soe;
  logic [1:0]    shold;
  wire  [1:0]    sd;
  logic [10:0]   half_n;
  logic          bclk;
  logic          fs;
  int            cnt;
  logic [31:0]   cap0;
  logic [31:0]   cap1;
  logic [31:0]   q;
  logic          e;
  logic          fso;
  logic          fsoe;
  int            n_mismatch = 0;
  int            checked = 0;
  int            cyc = 0;

  // Undriven lanes float so a missing drive never passes as a bit
  assign sd[0] = (soe[0] | shold[0]) ? so[0] : 1'bz;
  assign sd[1] = (soe[1] | shold[1]) ? so[1] : 1'bz;

  // Lowered pclk figure makes a 640-cycle frame read as 48 kHz
  astx_top #(.PCLK_HZ(30720000)) dut (.pclk(pclk), .presetn(presetn), .apb_req(req),
    .apb_rsp(rsp), .bclk_pin(bclk), .frame_sync_pin(fs), .frame_sync_o(fso),
    .frame_sync_oe(fsoe), .sdout_o(so), .sdout_oe(soe), .sdout_hold(shold),
    .clk_cfg(cfg), .record_mute(mute));
  astx_host_model m (.pclk(pclk), .presetn(presetn), .half_n(half_n), .sd(sd),
    .bclk(bclk), .fs(fs), .cnt(cnt), .cap0(cap0), .cap1(cap1));

  ////////////////////////////////////////////////////////////////////////////
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
    @(posedge pclk);
    req.penable <= 1'b1;
    do @(posedge pclk); while (rsp.pready !== 1'b1);
    q = rsp.prdata;
    e = rsp.pslverr;
    req <= '0;
  endtask

  // Waits for a fresh half of the given level, n samples into it
  task automatic wait_samp(input int n, input logic lvl);
    do @(posedge pclk); while (fs === lvl);
    do @(posedge pclk); while (!(cnt == n && fs === lvl));
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    apb(1'b0, 8'h00, 32'h0000_0000);
    `CHK(q, 32'h0000_000C)
    apb(1'b0, 8'h40, 32'h0000_0000);
    `CHK({e, q}, {1'b1, 32'h0000_0000})
  endtask

  task automatic t_detect();
    repeat (4) wait_samp(2, 1'b1);
    apb(1'b1, 8'h0C, 32'hFFFF_FFFF);
    apb(1'b0, 8'h0C, 32'h0000_0000);
    `CHK(q, 32'h0000_0144)
    `CHK(cfg, {1'b1, 4'h4, 4'h4, 12'h200})
    `CHK(mute, 1'b0)
  endtask

  task automatic t_lj();
    apb(1'b1, 8'h04, 32'h0084_1800);
    apb(1'b1, 8'h10, 32'hA5C3_0000);
    apb(1'b1, 8'h14, 32'h3C96_0000);
    apb(1'b1, 8'h18, 32'h5AA5_0000);
    apb(1'b1, 8'h1C, 32'h0FF0_0000);
    apb(1'b1, 8'h00, 32'h0000_0002);
    wait_samp(32, 1'b1);
    `CHK(cap0, 32'hA5C3_5AA5)
    wait_samp(32, 1'b0);
    `CHK(cap0, 32'h3C96_0FF0)
    apb(1'b1, 8'h00, 32'h0000_1002);
    wait_samp(32, 1'b1);
    `CHK(cap1[15:0], 16'h5AA5)
  endtask

  task automatic t_i2s();
    apb(1'b1, 8'h00, 32'h0000_0001);
    wait_samp(17, 1'b0);
    `CHK(cap0[15:0], 16'hA5C3)
    wait_samp(17, 1'b1);
    `CHK(cap0[15:0], 16'h3C96)
  endtask

  // All channels on left slot 0: the highest channel owns it
  task automatic t_tri();
    apb(1'b1, 8'h04, 32'h0000_0000);
    apb(1'b1, 8'h00, 32'h0000_0C01);
    wait_samp(8, 1'b0);
    `CHK(cap0[6:0], 7'h07)
    `CHK({soe[0], shold[0]}, 2'b10)
    wait_samp(8, 1'b1);
    `CHK({soe[0], shold[0]}, 2'b01)
    apb(1'b1, 8'h00, 32'h0000_0C03);
    wait_samp(10, 1'b0);
    `CHK(soe, 2'b00)
  endtask

  task automatic t_delay();
    apb(1'b1, 8'h00, 32'h0000_0032);
    wait_samp(19, 1'b1);
    `CHK(cap0[15:0], 16'h0FF0)
  endtask

  // Relaxed latching delays capture by one bit clock; inverting the clock
  // moves the late update onto the falling edge, ahead of the host's capture edge
  task automatic t_late();
    apb(1'b1, 8'h00, 32'h0000_2002);
    wait_samp(17, 1'b1);
    `CHK(cap0[15:0], 16'h0FF0)
    apb(1'b1, 8'h00, 32'h0000_2202);
    wait_samp(16, 1'b1);
    `CHK(cap0[15:0], 16'h0FF0)
  endtask

  // Own sync: moves only while bit clock is low, every HALF bit clocks
  task automatic t_master();
    int n;
    n = 0;
    apb(1'b1, 8'h08, 32'h0000_0010);
    apb(1'b1, 8'h00, 32'h0000_4001);
    do @(posedge pclk); while (fso !== 1'b1);
    `CHK({fsoe, bclk}, 2'b10)
    do begin
      @(posedge pclk);
      n++;
    end while (fso === 1'b1);
    `CHK(n, 160)
    apb(1'b1, 8'h00, 32'h0000_0002);
  endtask

  // Forty bit clocks per frame is no supported ratio
  task automatic t_err();
    half_n <= 11'd20;
    repeat (4) wait_samp(2, 1'b1);
    apb(1'b0, 8'h0C, 32'h0000_0000);
    `CHK(q[9], 1'b1)
    `CHK(mute, 1'b1)
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      n_mismatch++;
      end_sim();
    end
  end

  initial begin
    presetn = 1'b0;
    req = '0;
    half_n = 11'd32;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_detect();
    t_lj();
    t_i2s();
    t_tri();
    t_delay();
    t_late();
    t_master();
    t_err();
    end_sim();
  end
endmodule
